// >>> design/ic3_defines.svh
// Register offsets, field positions, reset values for the control-three block
`ifndef IC3_DEFINES_SVH
`define IC3_DEFINES_SVH
`define IC3_CTRL3_OFFSET 8'h48
`define IC3_CTRL3_INDEX 8'h12
`define IC3_CTRL3_RESET 8'h00
`define IC3_BIT_FULL 7
`define IC3_BIT_HEADROOM 6
`define IC3_BIT_FJT 5
`define IC3_BIT_LLB 4
`define IC3_BIT_FLHT 3
`define IC3_DCT_FCC 2'h2
`define IC3_RESP_OKAY 2'h0
`define IC3_RESP_SLVERR 2'h2
`endif

// >>> design/ic3_pkg.sv
// Types shared by the control-three block
package ic3_pkg;
    typedef enum logic [1:0] {
        IC3_TERM_LOWV = 2'h0,
        IC3_TERM_JAPAN = 2'h1,
        IC3_TERM_FCC = 2'h2,
        IC3_TERM_CTR21 = 2'h3
    } ic3_term_t;
    typedef struct packed {
        logic fullScaleHigh;
        logic dtmfHeadroom;
        ic3_term_t termMode;
        logic lowerLoopBias;
        logic [2:0] lowBits;
    } ic3_line_t;
endpackage : ic3_pkg

// >>> design/ic3_decode.sv
// Decode of the control byte into line-interface settings
`timescale 1ns/1ps
`default_nettype none
`include "ic3_defines.svh"
module ic3_decode (
    // Register and selection
    input wire logic [7:0] ctrlByte,
    input wire logic [1:0] dcTerminationSelect,
    // Decoded settings
    output ic3_pkg::ic3_line_t lineCfg
);
    import ic3_pkg::*;
    wire forceJapan = ctrlByte[`IC3_BIT_FJT];
    wire forceLow = ctrlByte[`IC3_BIT_FLHT];
    wire isFcc = (dcTerminationSelect == `IC3_DCT_FCC);
    wire ic3_term_t selTerm = ic3_term_t'(dcTerminationSelect);
    // Low-voltage force overrides the termination select and the Japan force
    wire ic3_term_t termMode = forceLow ? IC3_TERM_LOWV :
        ((isFcc && forceJapan) ? IC3_TERM_JAPAN : selTerm);
    assign lineCfg.fullScaleHigh = ctrlByte[`IC3_BIT_FULL];
    assign lineCfg.dtmfHeadroom = ctrlByte[`IC3_BIT_HEADROOM];
    assign lineCfg.termMode = termMode;
    assign lineCfg.lowerLoopBias = ctrlByte[`IC3_BIT_LLB];
    assign lineCfg.lowBits = ctrlByte[2:0];
endmodule : ic3_decode
`default_nettype wire

// >>> design/ic3_ctrl_three.sv
// Control-three register with AXI4-Lite slave and line-interface outputs
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ic3_defines.svh"
// Behaviour
// - Reset clears all eight register bits
// - Bit 7 selects +3.2 dBm converter scale
// - Bit 5 turns FCC termination into Japan
// - Bit 3 forces low-voltage termination
module ic3_ctrl_three (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Line interface
    input wire logic [1:0] dcTerminationSelect,
    output ic3_pkg::ic3_line_t lineCfg
);
    import ic3_pkg::*;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic [7:0] wByte_r;
    logic wLane_r;
    wire awTake = awvalid && awready;
    wire wTake = wvalid && wready;
    wire haveAw = awHeld_r || awTake;
    wire haveW = wHeld_r || wTake;
    wire [7:0] curAw = awHeld_r ? awAddr_r : awaddr;
    wire [7:0] curW = wHeld_r ? wByte_r : wdata[7:0];
    wire curLane = wHeld_r ? wLane_r : wstrb[0];
    wire doWrite = haveAw && haveW && !bvalid;
    wire wrHit = (curAw == `IC3_CTRL3_OFFSET);
    wire [7:0] ctrlNxt = (doWrite && wrHit && curLane) ? curW : ctrl_r;

    // Next-state terms; readies are flop copies so every output is registered
    wire awHeldNxt = haveAw && !doWrite;
    wire wHeldNxt = haveW && !doWrite;
    wire bvalidNxt = doWrite || (bvalid && !bready);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `IC3_CTRL3_RESET;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wByte_r <= 8'h00;
            wLane_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `IC3_RESP_OKAY;
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            ctrl_r <= ctrlNxt;
            awHeld_r <= awHeldNxt;
            wHeld_r <= wHeldNxt;
            awready <= !awHeldNxt && !bvalidNxt;
            wready <= !wHeldNxt && !bvalidNxt;
            if (awTake) begin
                awAddr_r <= awaddr;
            end
            if (wTake) begin
                wByte_r <= wdata[7:0];
                wLane_r <= wstrb[0];
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= wrHit ? `IC3_RESP_OKAY : `IC3_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire rdHit = (araddr == `IC3_CTRL3_OFFSET);
    wire arTake = arvalid && arready;
    wire rvalidNxt = arTake || (rvalid && !rready);

    // Ready reads high in reset, matching the idle bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b1;
        end else begin
            arready <= !rvalidNxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `IC3_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdHit ? {24'h00_0000, ctrl_r} : 32'h0000_0000;
            rresp <= rdHit ? `IC3_RESP_OKAY : `IC3_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Line-interface decode, registered
    // ------------------------------------------------------------
    // Select input is decoded live; caller keeps it stable
    ic3_line_t lineNxt;
    ic3_decode uDecode (
        .ctrlByte(ctrl_r),
        .dcTerminationSelect(dcTerminationSelect),
        .lineCfg(lineNxt)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineCfg <= '0;
        end else begin
            lineCfg <= lineNxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_clears: assert property (@(posedge clk) $rose(rst_b) |-> ctrl_r == 8'h00)
        else $error("control byte not clear after reset");
    a_full_scale: assert property (@(posedge clk) disable iff (!rst_b)
        lineCfg.fullScaleHigh == $past(ctrl_r[7]))
        else $error("full scale output wrong");
    a_japan_force: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl_r[3] && ctrl_r[5] && dcTerminationSelect == 2'h2)
        |=> lineCfg.termMode == IC3_TERM_JAPAN)
        else $error("japan force ignored");
    a_fcc_stands: assert property (@(posedge clk) disable iff (!rst_b)
        (ctrl_r[3:3] == 1'b0 && !ctrl_r[5] && dcTerminationSelect == 2'h2)
        |=> lineCfg.termMode == IC3_TERM_FCC)
        else $error("fcc selection lost");
    a_low_force: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_r[3] |=> lineCfg.termMode == IC3_TERM_LOWV)
        else $error("low voltage force ignored");
    a_bias_lower: assert property (@(posedge clk) disable iff (!rst_b)
        lineCfg.lowerLoopBias == $past(ctrl_r[4]))
        else $error("bias output wrong");
    a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
        (doWrite && wrHit && curLane) |=> ctrl_r == $past(curW))
        else $error("write data not stored");
    a_read_back: assert property (@(posedge clk) disable iff (!rst_b)
        (arvalid && arready && rdHit) |=> rvalid && rdata[7:0] == $past(ctrl_r))
        else $error("read data mismatch");
    a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_headroom_out: assert property (@(posedge clk) disable iff (!rst_b)
        lineCfg.dtmfHeadroom == $past(ctrl_r[6]))
        else $error("headroom output wrong");
    a_low_bits: assert property (@(posedge clk) disable iff (!rst_b)
        lineCfg.lowBits == $past(ctrl_r[2:0]))
        else $error("low bits output wrong");
    a_bad_write: assert property (@(posedge clk) disable iff (!rst_b)
        (doWrite && !wrHit) |=> ctrl_r == $past(ctrl_r))
        else $error("stray write changed register");
    a_lane_off: assert property (@(posedge clk) disable iff (!rst_b)
        (doWrite && !curLane) |=> ctrl_r == $past(ctrl_r))
        else $error("masked write changed register");
    a_write_resp: assert property (@(posedge clk) disable iff (!rst_b)
        doWrite |=> bvalid && bresp == ($past(wrHit) ? `IC3_RESP_OKAY : `IC3_RESP_SLVERR))
        else $error("write response code wrong");
    a_read_error: assert property (@(posedge clk) disable iff (!rst_b)
        (arTake && !rdHit) |=> rvalid && rresp == `IC3_RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("bad read address not refused");
    a_rvalid_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (rvalid && !rready) |=> rvalid && $stable(rdata))
        else $error("read response dropped");
    a_select_pass: assert property (@(posedge clk) disable iff (!rst_b)
        (!ctrl_r[3] && !(ctrl_r[5] && dcTerminationSelect == 2'h2))
        |=> lineCfg.termMode == $past(dcTerminationSelect))
        else $error("termination select not passed");
    // Readies must stay low while a response waits
    a_write_block: assert property (@(posedge clk) disable iff (!rst_b)
        bvalid |-> !awready && !wready)
        else $error("write taken with response pending");
    a_read_block: assert property (@(posedge clk) disable iff (!rst_b)
        rvalid |-> !arready)
        else $error("read taken with response pending");
    c_write_ok: cover property (@(posedge clk) doWrite && wrHit);
    c_read_ok: cover property (@(posedge clk) arvalid && arready && rdHit);
    c_japan: cover property (@(posedge clk) lineCfg.termMode == IC3_TERM_JAPAN);
    c_bad_addr: cover property (@(posedge clk) doWrite && !wrHit);
    c_low_force: cover property (@(posedge clk) lineCfg.termMode == IC3_TERM_LOWV && ctrl_r[3]);
endmodule : ic3_ctrl_three
`default_nettype wire

// >>> verif/tb_ic3_ctrl_three.sv
// Self-checking testbench for the control-three register block
`timescale 1ns/1ps
`default_nettype none
`include "ic3_defines.svh"
module tb_ic3_ctrl_three;
    import ic3_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, regv;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, sel;
    ic3_line_t lineCfg;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int numErrors = 0;
    int checks = 0;
    ic3_ctrl_three i_dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .dcTerminationSelect(sel), .lineCfg(lineCfg));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // Force-low wins over the Japan override
    function automatic ic3_line_t expLine(input logic [7:0] r, input logic [1:0] s);
        ic3_term_t t;
        t = r[3] ? IC3_TERM_LOWV : ((s == 2'h2 && r[5]) ? IC3_TERM_JAPAN : ic3_term_t'(s));
        return '{r[7], r[6], t, r[4], r[2:0]};
    endfunction : expLine
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (numErrors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Bus tasks; each channel released at its own handshake
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        wq.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge clk);
        while (awvalid || wvalid || bready) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
            @(posedge clk);
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk);
        while (arvalid || rready) begin
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
            @(posedge clk);
        end
    endtask : rd
    task automatic step(input logic [1:0] s, input logic [31:0] d, input logic [3:0] st);
        sel <= s;
        wr(`IC3_CTRL3_OFFSET, d, st, `IC3_RESP_OKAY);
        if (st[0]) regv = d[7:0];
        rd(`IC3_CTRL3_OFFSET, {`IC3_RESP_OKAY, 24'h0, regv});
        repeat (2) @(posedge clk);
        check({26'h0, lineCfg}, {26'h0, expLine(regv, sel)});
    endtask : step
    always @(posedge clk) begin
        if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, wq.pop_front()});
        if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, rq.pop_front());
    end
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, wstrb, sel, regv} = '0;
        seed = 32'h1CA6;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({26'h0, lineCfg}, 34'h0);
        rd(`IC3_CTRL3_OFFSET, 34'h0);
        for (int k = 0; k < 8; k++) step(k[1:0], {24'h0, 2'h0, 1'b1, 1'b0, k[2], 3'h5}, 4'hF);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            step(seed[9:8], seed, {3'h7, seed[12]});
        end
        // Full scale with FCC select, headroom raised for weak-line dialing
        step(2'h2, 32'h0000_00C0, 4'hF);
        // Printed index is not the byte address
        wr(`IC3_CTRL3_INDEX, 32'hFF, 4'hF, `IC3_RESP_SLVERR);
        rd(8'h4C, {`IC3_RESP_SLVERR, 32'h0});
        rd(`IC3_CTRL3_OFFSET, {`IC3_RESP_OKAY, 24'h0, regv});
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        test_done();
    end
endmodule : tb_ic3_ctrl_three
`default_nettype wire
